// >>> sim/sgpcr_regs_assertions.sv
// Concurrent checks on the switch global port control register bank
`timescale 1ns/1ps
module sgpcr_regs_assertions
  import sgpcr_pkg::*;
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  nrst,
  // Register port
  input wire logic [7:0]            regAddr,
  input wire logic [31:0]           regWdata,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [31:0]           regRdata,
  // Enables and scheduling
  input wire logic [NPORT-1:0]      portCountingOn,
  input wire logic [NPORT-1:0]      portPauseOn,
  input wire logic [NPORT-1:0]      lowerGrant,
  // Unload and pacing
  input wire logic                  unloadReq,
  input wire logic                  unloadDone,
  input wire logic                  unloadStart,
  input wire logic                  unloadBusy,
  input wire logic                  macRateSlot,
  // Thresholds
  input wire logic [GAP_W-1:0]      txBlockUsage,
  input wire logic                  txShortGap,
  input wire logic [WORD_CNT_W-1:0] egrBufWords,
  input wire logic                  egrPktComplete,
  input wire logic                  egrStartAllow,
  input wire logic                  egressThreadReady
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Shadows of the fields that gate outputs, kept from the write traffic alone
  logic             idleR;
  logic [GAP_W-1:0] gapR;
  logic [THR_W-1:0] thrR;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      idleR <= 1'b0;
      gapR  <= 5'h00;
      thrR  <= 10'h000;
    end else if (regWr) begin
      if (regAddr == 8'h14) idleR <= regWdata[0];
      if (regAddr == 8'h1C) gapR <= regWdata[4:0];
      if (regAddr == 8'h28) thrR <= regWdata[9:0];
    end
  end

  a_stat_write: assert property (regWr && regAddr == 8'h0C |=> portCountingOn == $past(regWdata[2:0]))
    else $error("statistics enables not taken from write");
  a_pause_write: assert property (regWr && regAddr == 8'h24 |=> portPauseOn == $past(regWdata[2:0]))
    else $error("pause enables not taken from write");
  a_unload_gate: assert property (unloadStart |-> unloadReq && !unloadBusy && !idleR)
    else $error("unload started while idle or busy");
  a_unload_launch: assert property (unloadReq && !unloadBusy && !idleR |-> unloadStart)
    else $error("pending unload not started");
  a_busy_follow: assert property (unloadStart |=> unloadBusy)
    else $error("busy missing after start");
  a_busy_hold: assert property (unloadBusy && !unloadDone |=> unloadBusy)
    else $error("unload dropped before done");
  a_short_gap: assert property (txShortGap == (txBlockUsage >= gapR))
    else $error("short gap disagrees with threshold");
  a_start_thresh: assert property (egrStartAllow == (egrPktComplete || egrBufWords >= {1'b0, thrR}))
    else $error("egress start disagrees with threshold");
  a_ready_plus2: assert property (egressThreadReady == (egrPktComplete || egrBufWords >= {1'b0, thrR} + 11'h002))
    else $error("thread ready disagrees with threshold plus two");
  a_mac_spacing: assert property (macRateSlot |=> !macRateSlot)
    else $error("MAC slots closer than two cycles");
  a_rdata_quiet: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read answer cycle");
  a_map_gaps: assert property ($past(regRd) && $past(regAddr) == 8'h3C |-> (regRdata & 32'h8888_8888) == 32'h0)
    else $error("map gap bits read nonzero");

  cover property (unloadBusy && idleR);
  cover property (|lowerGrant);
  cover property (egressThreadReady && !egrPktComplete);
endmodule

bind sgpcr_regs sgpcr_regs_assertions sgpcr_regs_assertions_inst (
  .mclk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .portCountingOn, .portPauseOn,
  .lowerGrant, .unloadReq, .unloadDone, .unloadStart, .unloadBusy, .macRateSlot, .txBlockUsage,
  .txShortGap, .egrBufWords, .egrPktComplete, .egrStartAllow, .egressThreadReady
);

// >>> sim/sgpcr_regs_bench.sv
// Self-checking bench for the switch global port control register bank
`timescale 1ns/1ps
module sgpcr_regs_bench
  import sgpcr_pkg::*;
;
  logic        mclk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic        unloadReq = 1'b0, unloadDone = 1'b0, egrPktComplete = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [2:0]  schedHighSent = 3'h0, hdrPri = 3'h0, switchQueuePri, lowerGrant;
  logic [2:0]  portCountingOn, portPauseOn, portEscalateSelect;
  logic [4:0]  txBlockUsage = 5'h00, escalateLoadCount;
  logic [10:0] txFifoWords = 11'h000, egrBufWords = 11'h000;
  logic        unloadStart, unloadBusy, macRateSlot, hostRateSlot;
  logic        txShortGap, txEgressAllow, egrStartAllow, egressThreadReady;
  logic [7:0]  transmitBlockAllocation, receiveBlockAllocation;
  sgpcr_vlan_s hostDefaultVlanTag;
  int          badCount = 0, checked = 0, cycles = 0, m, h;
  logic [7:0]  ofs [12] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h34, 8'h38, 8'h3C, 8'h2C};
  logic [31:0] rstv [12] = '{0, 0, 0, 32'h3003, 0, 32'h8, 0, 0, 0, 0, 32'h7654_3210, 0};
  logic [31:0] mask [12] = '{7, 32'h71F, 1, 32'hF00F, 32'h1F, 32'h7FF, 7, 32'h3FF, 32'hFFFF, 32'hFFFF, 32'h7777_7777, 0};

  sgpcr_regs sgpcr_regs_inst (
    .mclk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .portCountingOn, .portPauseOn,
    .portEscalateSelect, .escalateLoadCount, .schedHighSent, .lowerGrant, .unloadReq, .unloadDone,
    .unloadStart, .unloadBusy, .macRateSlot, .hostRateSlot, .txBlockUsage, .txShortGap, .txFifoWords,
    .txEgressAllow, .egrBufWords, .egrPktComplete, .egrStartAllow, .egressThreadReady,
    .transmitBlockAllocation, .receiveBlockAllocation, .hostDefaultVlanTag, .hdrPri, .switchQueuePri
  );

  always #4 mclk = ~mclk;

  task giveVerdict;
    $display("Checks %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      $display("[FAIL] %0t run did not finish", $time);
      giveVerdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  // Counting over whole periods makes the result independent of pacer phase
  task slots(input int n);
    m = 0;
    h = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      m += macRateSlot;
      h += hostRateSlot;
    end
  endtask

  task lvl(input int u, input int w, input int b, input logic c, input logic [3:0] exp);
    @(posedge mclk);
    txBlockUsage <= 5'(u);
    txFifoWords <= 11'(w);
    egrBufWords <= 11'(b);
    egrPktComplete <= c;
    #1 chk({txShortGap, txEgressAllow, egrStartAllow, egressThreadReady}, exp);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    slots(24);
    chk(m, 8);
    chk(h, 8);
    for (int i = 0; i < 12; i++) rd(ofs[i], rstv[i]);
    for (int i = 0; i < 12; i++) begin
      wr(ofs[i], 32'hFFFF_FFFF);
      rd(ofs[i], mask[i]);
    end
    wr(8'h18, 32'h0000_1006);
    repeat (8) @(posedge mclk);
    slots(24);
    chk(m, 12);
    chk(h, 4);
    wr(8'h0C, 32'h5);
    chk(portCountingOn, 5);
    wr(8'h24, 32'h2);
    chk(portPauseOn, 2);
    wr(8'h10, 32'h0000_0503);
    chk({portEscalateSelect, escalateLoadCount}, 32'hA3);
    wr(8'h34, 32'h0000_A53C);
    chk({transmitBlockAllocation, receiveBlockAllocation}, 32'hA53C);
    wr(8'h38, 32'h0000_B123);
    chk(hostDefaultVlanTag, 32'hB123);
    wr(8'h3C, 32'h0123_4567);
    for (int n = 0; n < 8; n++) begin
      @(posedge mclk);
      hdrPri <= 3'(n);
      #1 chk(switchQueuePri, 7 - n);
    end
    // Fourth send, the first after the grant, must clear the count again
    for (int k = 1; k < 5; k++) begin
      @(posedge mclk);
      schedHighSent <= 3'h7;
      @(posedge mclk);
      schedHighSent <= 3'h0;
      #1 chk(lowerGrant, (k == 3) ? 5 : 0);
    end
    wr(8'h14, 32'h0);
    @(posedge mclk);
    unloadReq <= 1'b1;
    #1 chk(unloadStart, 1);
    @(posedge mclk);
    #1 chk({unloadBusy, unloadStart}, 2);
    wr(8'h14, 32'h1);
    chk(unloadBusy, 1);
    @(posedge mclk);
    unloadDone <= 1'b1;
    @(posedge mclk);
    unloadDone <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk({unloadBusy, unloadStart}, 0);
    wr(8'h14, 32'h0);
    chk(unloadStart, 1);
    @(posedge mclk);
    unloadReq <= 1'b0;
    wr(8'h1C, 32'h5);
    wr(8'h20, 32'hA);
    wr(8'h28, 32'h4);
    lvl(4, 9, 3, 1'b0, 4'b0000);
    lvl(5, 10, 4, 1'b0, 4'b1110);
    lvl(31, 2047, 5, 1'b0, 4'b1110);
    lvl(0, 0, 6, 1'b0, 4'b0011);
    lvl(0, 0, 0, 1'b1, 4'b0011);
    rd(8'h40, 32'h0000_0005);
    giveVerdict();
  end
endmodule

// >>> src/sgpcr_pace.sv
// Rate pacer: one enable pulse every rate clock periods
`timescale 1ns/1ps
module sgpcr_pace
  import sgpcr_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Control
  input  wire logic [RATE_W-1:0] rate,
  // Pulse
  output logic                   slot
);

  logic [RATE_W-1:0] cnt_r;
  logic [RATE_W-1:0] cnt_nxt;

  always_comb begin
    if (cnt_r + 4'h1 >= rate) begin
      cnt_nxt = 4'h0;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign slot = (cnt_r == 4'h0);

endmodule

// >>> src/sgpcr_pkg.sv
// Package of register map, field layout and reset values for the switch global port control block
package sgpcr_pkg;

  // Register byte offsets (the map's printed offsets are word aligned)
  localparam logic [7:0] STAT_EN_OFS    = 8'h0C;
  localparam logic [7:0] PRI_TYPE_OFS   = 8'h10;
  localparam logic [7:0] IDLE_OFS       = 8'h14;
  localparam logic [7:0] RATE_OFS       = 8'h18;
  localparam logic [7:0] GAP_OFS        = 8'h1C;
  localparam logic [7:0] START_WDS_OFS  = 8'h20;
  localparam logic [7:0] PAUSE_OFS      = 8'h24;
  localparam logic [7:0] EGR_THR_OFS    = 8'h28;
  localparam logic [7:0] BLK_ALLOC_OFS  = 8'h34;
  localparam logic [7:0] VLAN_OFS       = 8'h38;
  localparam logic [7:0] PRI_MAP_OFS    = 8'h3C;
  localparam logic [7:0] STATUS_OFS     = 8'h40;

  // Field positions
  localparam int ESC_SEL_LSB   = 8;
  localparam int MAC_RATE_LSB  = 12;
  localparam int TX_BLK_LSB    = 8;
  localparam int VLAN_PRI_LSB  = 13;
  localparam int VLAN_CFI_BIT  = 12;

  // Field widths
  localparam int NPORT       = 3;
  localparam int ESC_W       = 5;
  localparam int RATE_W      = 4;
  localparam int GAP_W       = 5;
  localparam int START_W     = 11;
  localparam int THR_W       = 10;
  localparam int BLK_W       = 8;
  localparam int VID_W       = 12;
  localparam int PRI_W       = 3;
  localparam int WORD_CNT_W  = 11;

  // Reset values, the MAC rate floor and the egress threshold extra
  localparam logic [NPORT-1:0]   STAT_EN_RST   = 3'h0;
  localparam logic [NPORT-1:0]   ESC_SEL_RST   = 3'h0;
  localparam logic [ESC_W-1:0]   ESC_LOAD_RST  = 5'h00;
  localparam logic               IDLE_RST      = 1'b0;
  localparam logic [RATE_W-1:0]  MAC_RATE_RST  = 4'h3;
  localparam logic [RATE_W-1:0]  MAC_RATE_MIN  = 4'h2;
  localparam logic [RATE_W-1:0]  HOST_RATE_RST = 4'h3;
  localparam logic [GAP_W-1:0]   GAP_RST       = 5'h00;
  localparam logic [START_W-1:0] START_WDS_RST = 11'h008;
  localparam logic [THR_W-1:0]   EGR_THR_RST   = 10'h000;
  localparam logic [THR_W-1:0]   EGR_THR_EXTRA = 10'h002;
  localparam logic [BLK_W-1:0]   TX_BLK_RST    = 8'h00;
  localparam logic [BLK_W-1:0]   RX_BLK_RST    = 8'h00;
  localparam logic [NPORT-1:0]   PAUSE_RST     = 3'h0;
  localparam logic [15:0]        VLAN_RST      = 16'h0000;
  localparam logic [31:0]        PRI_MAP_RST   = 32'h7654_3210;

  typedef struct packed {
    logic [PRI_W-1:0] pri;
    logic             cfi;
    logic [VID_W-1:0] vid;
  } sgpcr_vlan_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sgpcr_bus_s;

  typedef enum logic [1:0] {
    UNLOAD_IDLE = 2'b00,
    UNLOAD_BUSY = 2'b01
  } sgpcr_unload_e;

endpackage

// >>> src/sgpcr_regs.sv
// Switch global port control register bank and the control it exerts
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module sgpcr_regs
  import sgpcr_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  // Register port
  input  wire logic [7:0]            regAddr,
  input  wire logic [31:0]           regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic [31:0]                regRdata,
  // Statistics and pause enables
  output logic [NPORT-1:0]           portCountingOn,
  output logic [NPORT-1:0]           portPauseOn,
  // Transmit priority scheduling
  output logic [NPORT-1:0]           portEscalateSelect,
  output logic [ESC_W-1:0]           escalateLoadCount,
  input  wire logic [NPORT-1:0]      schedHighSent,
  output logic [NPORT-1:0]           lowerGrant,
  // Receive unload
  input  wire logic                  unloadReq,
  input  wire logic                  unloadDone,
  output logic                       unloadStart,
  output logic                       unloadBusy,
  // Through rate pacing
  output logic                       macRateSlot,
  output logic                       hostRateSlot,
  // Transmit FIFO
  input  wire logic [GAP_W-1:0]      txBlockUsage,
  output logic                       txShortGap,
  input  wire logic [START_W-1:0]    txFifoWords,
  output logic                       txEgressAllow,
  // Host egress stream
  input  wire logic [WORD_CNT_W-1:0] egrBufWords,
  input  wire logic                  egrPktComplete,
  output logic                       egrStartAllow,
  output logic                       egressThreadReady,
  // Host queue configuration
  output logic [BLK_W-1:0]           transmitBlockAllocation,
  output logic [BLK_W-1:0]           receiveBlockAllocation,
  output sgpcr_vlan_s                hostDefaultVlanTag,
  // Header priority mapping
  input  wire logic [PRI_W-1:0]      hdrPri,
  output logic [PRI_W-1:0]           switchQueuePri
);

  sgpcr_bus_s          bus;
  logic [NPORT-1:0]    statEn_r;
  logic [NPORT-1:0]    statEn_nxt;
  logic [NPORT-1:0]    escSel_r;
  logic [NPORT-1:0]    escSel_nxt;
  logic [ESC_W-1:0]    escLoad_r;
  logic [ESC_W-1:0]    escLoad_nxt;
  logic                idle_r;
  logic                idle_nxt;
  logic [RATE_W-1:0]   macRate_r;
  logic [RATE_W-1:0]   macRate_nxt;
  logic [RATE_W-1:0]   hostRate_r;
  logic [RATE_W-1:0]   hostRate_nxt;
  logic [GAP_W-1:0]    gap_r;
  logic [GAP_W-1:0]    gap_nxt;
  logic [START_W-1:0]  startWds_r;
  logic [START_W-1:0]  startWds_nxt;
  logic [NPORT-1:0]    pause_r;
  logic [NPORT-1:0]    pause_nxt;
  logic [THR_W-1:0]    egrThr_r;
  logic [THR_W-1:0]    egrThr_nxt;
  logic [BLK_W-1:0]    txBlk_r;
  logic [BLK_W-1:0]    txBlk_nxt;
  logic [BLK_W-1:0]    rxBlk_r;
  logic [BLK_W-1:0]    rxBlk_nxt;
  sgpcr_vlan_s         vlan_r;
  sgpcr_vlan_s         vlan_nxt;
  logic [31:0]         priMap_r;
  logic [31:0]         priMap_nxt;
  logic [31:0]         rdata_r;
  logic [31:0]         rdata_nxt;
  sgpcr_unload_e       unl_r;
  sgpcr_unload_e       unl_nxt;
  // One escalation counter per port, counting higher-priority sends
  logic [ESC_W-1:0]    escCnt_r [NPORT];
  logic [ESC_W-1:0]    escCnt_nxt [NPORT];
  logic [RATE_W-1:0]   macRateUse;
  // Fill-level operands carry a spare bit so threshold plus two cannot wrap
  logic [WORD_CNT_W:0] egrWordsExt;
  logic [WORD_CNT_W:0] egrStartLevel;
  logic [WORD_CNT_W:0] egrReadyLevel;

  // Bus fields travel as one bundle so decode and read mux see the same sample
  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Register writes; only defined field bits are stored
  always_comb begin
    statEn_nxt   = statEn_r;
    escSel_nxt   = escSel_r;
    escLoad_nxt  = escLoad_r;
    idle_nxt     = idle_r;
    macRate_nxt  = macRate_r;
    hostRate_nxt = hostRate_r;
    gap_nxt      = gap_r;
    startWds_nxt = startWds_r;
    pause_nxt    = pause_r;
    egrThr_nxt   = egrThr_r;
    txBlk_nxt    = txBlk_r;
    rxBlk_nxt    = rxBlk_r;
    vlan_nxt     = vlan_r;
    priMap_nxt   = priMap_r;
    // Gap bits of the priority map are masked so they always read back as zero
    if (bus.wr) begin
      case (bus.addr)
        STAT_EN_OFS: statEn_nxt = bus.wdata[NPORT-1:0];
        PRI_TYPE_OFS: begin
          escSel_nxt  = bus.wdata[ESC_SEL_LSB +: NPORT];
          escLoad_nxt = bus.wdata[ESC_W-1:0];
        end
        IDLE_OFS: idle_nxt = bus.wdata[0];
        RATE_OFS: begin
          macRate_nxt  = bus.wdata[MAC_RATE_LSB +: RATE_W];
          hostRate_nxt = bus.wdata[RATE_W-1:0];
        end
        GAP_OFS: gap_nxt = bus.wdata[GAP_W-1:0];
        START_WDS_OFS: startWds_nxt = bus.wdata[START_W-1:0];
        PAUSE_OFS: pause_nxt = bus.wdata[NPORT-1:0];
        EGR_THR_OFS: egrThr_nxt = bus.wdata[THR_W-1:0];
        BLK_ALLOC_OFS: begin
          txBlk_nxt = bus.wdata[TX_BLK_LSB +: BLK_W];
          rxBlk_nxt = bus.wdata[BLK_W-1:0];
        end
        VLAN_OFS: begin
          vlan_nxt.pri = bus.wdata[VLAN_PRI_LSB +: PRI_W];
          vlan_nxt.cfi = bus.wdata[VLAN_CFI_BIT];
          vlan_nxt.vid = bus.wdata[VID_W-1:0];
        end
        PRI_MAP_OFS: priMap_nxt = bus.wdata & 32'h7777_7777;
        default: ;
      endcase
    end
  end

  // Read mux; reserved bits and unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        STAT_EN_OFS:   rdata_nxt[NPORT-1:0] = statEn_r;
        PRI_TYPE_OFS: begin
          rdata_nxt[ESC_SEL_LSB +: NPORT] = escSel_r;
          rdata_nxt[ESC_W-1:0]            = escLoad_r;
        end
        IDLE_OFS:      rdata_nxt[0] = idle_r;
        RATE_OFS: begin
          rdata_nxt[MAC_RATE_LSB +: RATE_W] = macRate_r;
          rdata_nxt[RATE_W-1:0]             = hostRate_r;
        end
        GAP_OFS:       rdata_nxt[GAP_W-1:0]   = gap_r;
        START_WDS_OFS: rdata_nxt[START_W-1:0] = startWds_r;
        PAUSE_OFS:     rdata_nxt[NPORT-1:0]   = pause_r;
        EGR_THR_OFS:   rdata_nxt[THR_W-1:0]   = egrThr_r;
        BLK_ALLOC_OFS: begin
          rdata_nxt[TX_BLK_LSB +: BLK_W] = txBlk_r;
          rdata_nxt[BLK_W-1:0]           = rxBlk_r;
        end
        VLAN_OFS:      rdata_nxt[15:0] = vlan_r;
        PRI_MAP_OFS:   rdata_nxt = priMap_r;
        // Status word is read-only; a write to its offset falls to the default branch
        STATUS_OFS: begin
          rdata_nxt[0] = unl_r == UNLOAD_BUSY;
          rdata_nxt[1] = txShortGap;
          rdata_nxt[2] = egressThreadReady;
        end
        default: ;
      endcase
    end
  end

  // Register file; every field returns to its reset value while nrst is low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      statEn_r   <= STAT_EN_RST;
      escSel_r   <= ESC_SEL_RST;
      escLoad_r  <= ESC_LOAD_RST;
      idle_r     <= IDLE_RST;
      macRate_r  <= MAC_RATE_RST;
      hostRate_r <= HOST_RATE_RST;
      gap_r      <= GAP_RST;
      startWds_r <= START_WDS_RST;
      pause_r    <= PAUSE_RST;
      egrThr_r   <= EGR_THR_RST;
      txBlk_r    <= TX_BLK_RST;
      rxBlk_r    <= RX_BLK_RST;
      vlan_r     <= VLAN_RST;
      priMap_r   <= PRI_MAP_RST;
      rdata_r    <= 32'h0000_0000;
    end else begin
      statEn_r   <= statEn_nxt;
      escSel_r   <= escSel_nxt;
      escLoad_r  <= escLoad_nxt;
      idle_r     <= idle_nxt;
      macRate_r  <= macRate_nxt;
      hostRate_r <= hostRate_nxt;
      gap_r      <= gap_nxt;
      startWds_r <= startWds_nxt;
      pause_r    <= pause_nxt;
      egrThr_r   <= egrThr_nxt;
      txBlk_r    <= txBlk_nxt;
      rxBlk_r    <= rxBlk_nxt;
      vlan_r     <= vlan_nxt;
      priMap_r   <= priMap_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // Read data leaves a flip-flop; it is zero outside the answer cycle
  assign regRdata = rdata_r;

  // Configuration outputs straight from registers
  assign portCountingOn          = statEn_r;
  assign portPauseOn             = pause_r;
  assign portEscalateSelect      = escSel_r;
  assign escalateLoadCount       = escLoad_r;
  assign transmitBlockAllocation = txBlk_r;
  assign receiveBlockAllocation  = rxBlk_r;
  assign hostDefaultVlanTag      = vlan_r;

  // Escalation: count higher-priority sends, grant lower priority once the load count is met
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      escCnt_nxt[p] = escCnt_r[p];
      lowerGrant[p] = 1'b0;
      if (escSel_r[p]) begin
        if (escCnt_r[p] >= escLoad_r) begin
          lowerGrant[p] = 1'b1;
          if (schedHighSent[p]) begin
            escCnt_nxt[p] = 5'h00;
          end
        end else if (schedHighSent[p]) begin
          escCnt_nxt[p] = escCnt_r[p] + 5'h01;
        end
      end else begin
        escCnt_nxt[p] = 5'h00;
      end
    end
  end

  // Counters clear here on reset only; fixed-priority ports are zeroed in the comb path
  always_ff @(posedge mclk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (!nrst) begin
        escCnt_r[p] <= 5'h00;
      end else begin
        escCnt_r[p] <= escCnt_nxt[p];
      end
    end
  end

  // Receive unload gate: idle blocks only new starts, not one in flight
  always_comb begin
    unl_nxt     = unl_r;
    unloadStart = 1'b0;
    case (unl_r)
      UNLOAD_IDLE: begin
        if (unloadReq && !idle_r) begin
          unloadStart = 1'b1;
          unl_nxt     = UNLOAD_BUSY;
        end
      end
      UNLOAD_BUSY: begin
        if (unloadDone) begin
          unl_nxt = UNLOAD_IDLE;
        end
      end
      default: unl_nxt = UNLOAD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      unl_r <= UNLOAD_IDLE;
    end else begin
      unl_r <= unl_nxt;
    end
  end

  // Busy shows on the status word as well as on its own pin
  assign unloadBusy = unl_r == UNLOAD_BUSY;

  // Values below the floor would overrun the crossbar, so they are clamped
  assign macRateUse = (macRate_r < MAC_RATE_MIN) ? MAC_RATE_MIN : macRate_r;

  sgpcr_pace macPace (
    .mclk (mclk),
    .nrst (nrst),
    .rate (macRateUse),
    .slot (macRateSlot)
  );

  // A host rate of zero or one gives a slot on every cycle
  sgpcr_pace hostPace (
    .mclk (mclk),
    .nrst (nrst),
    .rate (hostRate_r),
    .slot (hostRateSlot)
  );

  // Threshold compares stay combinational so gating follows the live fill levels
  assign txShortGap = txBlockUsage >= gap_r;
  // A zero setting would allow underrun; software is expected to avoid it
  assign txEgressAllow = txFifoWords >= startWds_r;

  assign egrWordsExt       = {1'b0, egrBufWords};
  assign egrStartLevel     = {2'b00, egrThr_r};
  assign egrReadyLevel     = {2'b00, egrThr_r} + {2'b00, EGR_THR_EXTRA};
  assign egrStartAllow     = egrPktComplete || (egrWordsExt >= egrStartLevel);
  assign egressThreadReady = egrPktComplete || (egrWordsExt >= egrReadyLevel);

  // Lookup is combinational: the queue choice follows the header in the same cycle
  assign switchQueuePri = priMap_r[{hdrPri, 2'b00} +: PRI_W];

endmodule
